// ===== rtl/pdmh_defines.svh
// register map, field positions, reset values and timing counts of the power-down block
`ifndef PDMH_DEFINES_SVH
`define PDMH_DEFINES_SVH
`define PDMH_ADDR_W          20
`define PDMH_SYSCTL_ADDR     20'hE_E012
`define PDMH_HALT_HI_ADDR    20'hE_E01C
`define PDMH_HALT_LO_ADDR    20'hE_E01D
`define PDMH_SYSCTL_RESET    8'h09
`define PDMH_HALT_HI_RESET   8'h78
`define PDMH_HALT_LO_RESET   8'h00
`define PDMH_HALT_HI_FIXED   8'h78
`define PDMH_HW_STANDBY_N_SEL_BIT    7
`define PDMH_SETTLE_MSB      6
`define PDMH_SETTLE_LSB      4
`define PDMH_CLK_OFF_BIT     7
`define PDMH_HALT_SER1_BIT   1
`define PDMH_HALT_SER0_BIT   0
`define PDMH_HALT_T16_BIT    4
`define PDMH_HALT_T8A_BIT    3
`define PDMH_HALT_T8B_BIT    2
`define PDMH_HALT_ADC_BIT    0
`define PDMH_SETTLE_SHORT    3'h6
`define PDMH_SETTLE_BAD      3'h7
`define PDMH_SETTLE_W        19
`define PDMH_SETTLE_BASE     19'h0_2000
`define PDMH_SETTLE_1K       19'h0_0400
`endif

// ===== rtl/pdmh_pkg.sv
// types shared by the power-down block
package pdmh_pkg;
  typedef enum logic [2:0] {
    PDMH_RUN,
    PDMH_SLEEP,
    PDMH_SW_STANDBY,
    PDMH_SETTLE,
    PDMH_HW_STANDBY
  } pdmh_mode_t;
endpackage

// ===== rtl/pdmh_pin_sync.sv
// three-stage pin synchroniser, change taken once stages two and three agree
`timescale 1ns/1ps
module pdmh_pin_sync
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1;
  logic s2;
  logic s3;

  // resets to inactive-high so idle low-active pins do not fire at start
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end
    else
    begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      level_out <= 1'b1;
    else if (s2 == s3)
      level_out <= s3;
  end
endmodule

// ===== rtl/pdmh_core.sv
// power-down mode sequencer and module-halt registers
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "pdmh_defines.svh"

// Notes on behaviour
// - halt with standby-select 0 enters sleep
// - sleep ends on interrupt, reset, standby pin
// - halt with standby-select 1 stops clock, resets peripherals
// - interrupt exit waits selected settling count
// - standby pin low stops all, tri-states outputs
// - module halts work in every mode except hardware standby, which reloads the halt registers and clears them
// - haltable: timer16, timer8, serial0, serial1, adc
// - halt bit set halts and resets peripheral
// - high halt register clock-off, serial bits, fixed ones
// - low halt register timer and adc bits
// - system control register at EE012, reset 09
// - high halt register at EE01C, reset 78
// - low halt register at EE01D, reset 00
// - decode lower twenty address bits
module pdmh_core
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        reset_pin_n_in,
  input  wire logic        hw_standby_n_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        write_in,
  input  wire logic        read_in,
  output logic      [7:0]  rdata_out,
  input  wire logic        halt_exec_in,
  input  wire logic        irq_any_in,
  input  wire logic        nmi_in,
  input  wire logic [2:0]  ext_irq_in,
  output logic             cpu_stop_out,
  output logic             cpu_regs_lost_out,
  output logic             clock_stop_out,
  output logic             periph_reset_out,
  output logic             halt_timer16_out,
  output logic             halt_timer8_ch01_out,
  output logic             halt_timer8_ch23_out,
  output logic             halt_serial0_out,
  output logic             halt_serial1_out,
  output logic             halt_adc_out,
  output logic             clk_out_level_out,
  output logic             clk_out_oe_out,
  output logic             io_hold_out,
  output logic             io_oe_out,
  output logic [2:0]       mode_out
);
  pdmh_pkg::pdmh_mode_t mode;
  pdmh_pkg::pdmh_mode_t next_mode;
  logic [7:0]                   system_power_control;
  logic [7:0]                   module_halt_high;
  logic [7:0]                   module_halt_low;
  logic [`PDMH_SETTLE_W-1:0]    settle_cnt;
  logic                         reset_pin_n;
  logic                         hw_standby_n;
  logic                         hold_off;
  logic [`PDMH_ADDR_W-1:0]      addr_lo;
  logic                         standby_select;
  logic [2:0]                   settle_wait_select;
  logic                         wake_sw;
  logic                         clock_out_disable;

  // settling states: 8192 shifted by code, code 110 gives 1024
  function automatic logic [`PDMH_SETTLE_W-1:0] settle_len(input logic [2:0] code);
    if (code == `PDMH_SETTLE_SHORT)
      settle_len = `PDMH_SETTLE_1K;
    else if (code == `PDMH_SETTLE_BAD)
      settle_len = `PDMH_SETTLE_1K; // illegal code, shortest wait kept harmless
    else
      settle_len = `PDMH_SETTLE_BASE << code;
  endfunction

  pdmh_pin_sync u_sync_reset
  (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (reset_pin_n_in),
    .level_out (reset_pin_n)
  );

  pdmh_pin_sync u_sync_hw_standby_n
  (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (hw_standby_n_in),
    .level_out (hw_standby_n)
  );

  assign hold_off           = !reset_pin_n || !hw_standby_n;
  assign addr_lo            = addr_in[`PDMH_ADDR_W-1:0];
  assign standby_select     = system_power_control[`PDMH_HW_STANDBY_N_SEL_BIT];
  assign settle_wait_select = system_power_control[`PDMH_SETTLE_MSB:`PDMH_SETTLE_LSB];
  assign clock_out_disable  = module_halt_high[`PDMH_CLK_OFF_BIT];
  assign wake_sw            = nmi_in || (|ext_irq_in);

  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      pdmh_pkg::PDMH_RUN:
        if (halt_exec_in)
          next_mode = standby_select ? pdmh_pkg::PDMH_SW_STANDBY : pdmh_pkg::PDMH_SLEEP;
      pdmh_pkg::PDMH_SLEEP:
        if (irq_any_in)
          next_mode = pdmh_pkg::PDMH_RUN;
      pdmh_pkg::PDMH_SW_STANDBY:
        if (wake_sw)
          next_mode = pdmh_pkg::PDMH_SETTLE;
      pdmh_pkg::PDMH_SETTLE:
        if (settle_cnt == '0)
          next_mode = pdmh_pkg::PDMH_RUN;
      pdmh_pkg::PDMH_HW_STANDBY:
        if (hw_standby_n)
          next_mode = pdmh_pkg::PDMH_RUN;
    endcase
    // pins win over everything; reset pin returns to run, standby pin holds standby
    if (!hw_standby_n)
      next_mode = pdmh_pkg::PDMH_HW_STANDBY;
    else if (!reset_pin_n)
      next_mode = pdmh_pkg::PDMH_RUN;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      mode <= pdmh_pkg::PDMH_RUN;
    else
      mode <= next_mode;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      settle_cnt <= '0;
    else if (mode == pdmh_pkg::PDMH_SW_STANDBY && next_mode == pdmh_pkg::PDMH_SETTLE)
      settle_cnt <= settle_len(settle_wait_select) - 1'b1;
    else if (mode == pdmh_pkg::PDMH_SETTLE && settle_cnt != '0)
      settle_cnt <= settle_cnt - 1'b1;
  end

  // registers reinitialise on reset pin and hardware standby, not software standby
  always_ff @(posedge clk_in)
  begin
    if (rst_in || hold_off)
      system_power_control <= `PDMH_SYSCTL_RESET;
    else if (write_in && addr_lo == `PDMH_SYSCTL_ADDR)
      system_power_control <= wdata_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || hold_off)
      module_halt_high <= `PDMH_HALT_HI_RESET;
    else if (write_in && addr_lo == `PDMH_HALT_HI_ADDR)
      module_halt_high <= wdata_in | `PDMH_HALT_HI_FIXED;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || hold_off)
      module_halt_low <= `PDMH_HALT_LO_RESET;
    else if (write_in && addr_lo == `PDMH_HALT_LO_ADDR)
      module_halt_low <= wdata_in;
  end

  // unmapped addresses read zero
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rdata_out <= 8'h00;
    else if (read_in)
    begin
      unique case (addr_lo)
        `PDMH_SYSCTL_ADDR:  rdata_out <= system_power_control;
        `PDMH_HALT_HI_ADDR: rdata_out <= module_halt_high;
        `PDMH_HALT_LO_ADDR: rdata_out <= module_halt_low;
        default:            rdata_out <= 8'h00;
      endcase
    end
    else
      rdata_out <= 8'h00;
  end

  // software later clears a halt bit before reprogramming; halt stays reset-asserted until then
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      halt_timer16_out     <= 1'b0;
      halt_timer8_ch01_out <= 1'b0;
      halt_timer8_ch23_out <= 1'b0;
      halt_serial0_out     <= 1'b0;
      halt_serial1_out     <= 1'b0;
      halt_adc_out         <= 1'b0;
    end
    else
    begin
      // independent of mode so halts persist through sleep
      halt_timer16_out     <= module_halt_low[`PDMH_HALT_T16_BIT];
      halt_timer8_ch01_out <= module_halt_low[`PDMH_HALT_T8A_BIT];
      halt_timer8_ch23_out <= module_halt_low[`PDMH_HALT_T8B_BIT];
      halt_adc_out         <= module_halt_low[`PDMH_HALT_ADC_BIT];
      halt_serial1_out     <= module_halt_high[`PDMH_HALT_SER1_BIT];
      halt_serial0_out     <= module_halt_high[`PDMH_HALT_SER0_BIT];
    end
  end

  // outputs follow next_mode so they change with the mode register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cpu_stop_out      <= 1'b0;
      cpu_regs_lost_out <= 1'b0;
      clock_stop_out    <= 1'b0;
      periph_reset_out  <= 1'b0;
      io_hold_out       <= 1'b0;
      io_oe_out         <= 1'b1;
      mode_out          <= 3'h0;
    end
    else
    begin
      cpu_stop_out      <= next_mode != pdmh_pkg::PDMH_RUN;
      cpu_regs_lost_out <= next_mode == pdmh_pkg::PDMH_HW_STANDBY;
      clock_stop_out    <= next_mode inside {pdmh_pkg::PDMH_SW_STANDBY, pdmh_pkg::PDMH_SETTLE,
                                             pdmh_pkg::PDMH_HW_STANDBY};
      periph_reset_out  <= next_mode inside {pdmh_pkg::PDMH_SW_STANDBY, pdmh_pkg::PDMH_HW_STANDBY};
      io_hold_out       <= next_mode inside {pdmh_pkg::PDMH_SLEEP, pdmh_pkg::PDMH_SW_STANDBY};
      io_oe_out         <= next_mode != pdmh_pkg::PDMH_HW_STANDBY;
      mode_out          <= 3'(next_mode);
    end
  end

  // clock pin: high in software standby, floats in hw standby or when disabled
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      clk_out_level_out <= 1'b0;
      clk_out_oe_out    <= 1'b1;
    end
    else
    begin
      clk_out_level_out <= next_mode inside {pdmh_pkg::PDMH_SW_STANDBY, pdmh_pkg::PDMH_SETTLE};
      clk_out_oe_out    <= next_mode != pdmh_pkg::PDMH_HW_STANDBY && !clock_out_disable;
    end
  end
endmodule

// ===== verif/pdmh_core_asserts.sv
// concurrent checks on the power-down sequencer ports
`timescale 1ns/1ps
`include "pdmh_defines.svh"
module pdmh_core_asserts
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        reset_pin_n_in,
  input wire logic        hw_standby_n_in,
  input wire logic [23:0] addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        write_in,
  input wire logic        read_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        halt_exec_in,
  input wire logic        irq_any_in,
  input wire logic        nmi_in,
  input wire logic [2:0]  ext_irq_in,
  input wire logic        cpu_stop_out,
  input wire logic        clock_stop_out,
  input wire logic        periph_reset_out,
  input wire logic        halt_adc_out,
  input wire logic        clk_out_oe_out,
  input wire logic        io_oe_out,
  input wire logic [2:0]  mode_out
);
  logic [18:0] settle_cnt;
  // cleared outside settle so each wait is measured from zero
  always_ff @(posedge clk_in)
    if (rst_in || mode_out != 3'h3)
      settle_cnt <= 19'h0_0000;
    else
      settle_cnt <= settle_cnt + 19'h0_0001;
  logic [2:0]  settle_code;
  logic [18:0] settle_exp;
  // wait code as last written; either pin low brings back the reset code
  always_ff @(posedge clk_in)
    if (rst_in || !reset_pin_n_in || !hw_standby_n_in)
      settle_code <= 3'(`PDMH_SYSCTL_RESET >> `PDMH_SETTLE_LSB);
    else if (write_in && addr_in[19:0] == `PDMH_SYSCTL_ADDR)
      settle_code <= wdata_in[`PDMH_SETTLE_MSB:`PDMH_SETTLE_LSB];
  // code 6 is the short wait; illegal code 7 is held to the short wait too
  assign settle_exp = (settle_code >= `PDMH_SETTLE_SHORT) ? `PDMH_SETTLE_1K : `PDMH_SETTLE_BASE << settle_code;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_wr_lo;
    write_in && addr_in[19:0] == `PDMH_HALT_LO_ADDR;
  endsequence
  sequence s_rd_hi;
    read_in && addr_in[19:0] == `PDMH_HALT_HI_ADDR;
  endsequence
  sequence s_settle_done;
    $past(mode_out) == 3'h3 && mode_out == 3'h0;
  endsequence
  AST_RD_IDLE: assert property (!$past(read_in) |-> rdata_out == 8'h00)
    else $error("read data not idle");
  AST_RD_HI_FIXED: assert property (s_rd_hi |=> rdata_out[6:3] == 4'hF)
    else $error("fixed high bits not ones");
  AST_HALT_ADC: assert property (s_wr_lo |-> ##2 halt_adc_out == $past(wdata_in[0], 2))
    else $error("converter halt not following write");
  AST_HALT_ENTRY: assert property (mode_out == 3'h0 && halt_exec_in |=> mode_out inside {3'h1, 3'h2})
    else $error("halt did not stop processor");
  AST_SLEEP_WAKE: assert property (mode_out == 3'h1 && irq_any_in |=> mode_out == 3'h0)
    else $error("sleep not left on interrupt");
  AST_SW_HOLD: assert property (mode_out == 3'h2 && !nmi_in && ext_irq_in == 3'h0 |=> mode_out == 3'h2)
    else $error("standby left without wake source");
  AST_SW_STOP: assert property (mode_out == 3'h2 |-> cpu_stop_out && clock_stop_out && periph_reset_out)
    else $error("standby outputs wrong");
  AST_HW_HW_STANDBY_N: assert property (mode_out == 3'h4 |-> !io_oe_out && !clk_out_oe_out)
    else $error("pins driven in hardware standby");
  AST_SETTLE: assert property (s_settle_done |-> settle_cnt == settle_exp)
    else $error("settle length wrong");
endmodule
bind pdmh_core pdmh_core_asserts u_chk
(
  .clk_in           (clk_in),
  .rst_in           (rst_in),
  .reset_pin_n_in   (reset_pin_n_in),
  .hw_standby_n_in  (hw_standby_n_in),
  .addr_in          (addr_in),
  .wdata_in         (wdata_in),
  .write_in         (write_in),
  .read_in          (read_in),
  .rdata_out        (rdata_out),
  .halt_exec_in     (halt_exec_in),
  .irq_any_in       (irq_any_in),
  .nmi_in           (nmi_in),
  .ext_irq_in       (ext_irq_in),
  .cpu_stop_out     (cpu_stop_out),
  .clock_stop_out   (clock_stop_out),
  .periph_reset_out (periph_reset_out),
  .halt_adc_out     (halt_adc_out),
  .clk_out_oe_out   (clk_out_oe_out),
  .io_oe_out        (io_oe_out),
  .mode_out         (mode_out)
);

// ===== verif/pdmh_partner.sv
// interrupt sources on the processor side of the power-down block
`timescale 1ns/1ps
module pdmh_partner
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] mode_in,
  input  wire logic [1:0] kind_in,
  input  wire logic [7:0] lag_in,
  output logic            irq_any_out,
  output logic            nmi_out,
  output logic [2:0]      ext_irq_out
);
  logic [7:0] cnt;
  logic       fire;
  // a request stays pending until the core runs again
  always_ff @(posedge clk_in)
    if (rst_in || mode_in == 3'h0)
    begin
      cnt  <= 8'h00;
      fire <= 1'b0;
    end
    else if (cnt == lag_in)
      fire <= 1'b1;
    else
      cnt <= cnt + 8'h01;
  assign irq_any_out = fire && kind_in == 2'h1;
  assign nmi_out     = fire && kind_in == 2'h2;
  assign ext_irq_out = {fire && kind_in == 2'h3, 2'h0};
endmodule

// ===== verif/pdmh_core_tb.sv
// self-checking bench for the power-down sequencer
`timescale 1ns/1ps
`include "pdmh_defines.svh"
module pdmh_core_tb;
  logic        clk_in, rst_in, reset_pin_n_in, hw_standby_n_in, write_in, read_in, halt_exec_in;
  logic        irq_any_in, nmi_in, cpu_stop_out, cpu_regs_lost_out, clock_stop_out, periph_reset_out;
  logic        halt_timer16_out, halt_timer8_ch01_out, halt_timer8_ch23_out, halt_serial0_out;
  logic        halt_serial1_out, halt_adc_out, clk_out_level_out, clk_out_oe_out, io_hold_out, io_oe_out;
  logic [23:0] addr_in;
  logic [7:0]  wdata_in, rdata_out, lag, d;
  logic [2:0]  ext_irq_in, mode_out;
  logic [1:0]  kind;
  logic [19:0] ra[4];
  int          err_count, n_compared, i, k, n, m[4];
  pdmh_core uut (.*);
  pdmh_partner far_side (.clk_in, .rst_in, .mode_in(mode_out), .kind_in(kind), .lag_in(lag),
                         .irq_any_out(irq_any_in), .nmi_out(nmi_in), .ext_irq_out(ext_irq_in));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input logic rd, input int r, input logic [7:0] v);
    @(posedge clk_in);
    {read_in, write_in} <= {rd, !rd};
    addr_in <= {4'($urandom), ra[r]};
    wdata_in <= v;
    @(posedge clk_in);
    {read_in, write_in} <= 2'b00;
    #1;
    if (rd)
      check(rdata_out, m[r][7:0]);
  endtask
  task automatic reset_regs();
    m = '{8'h09, 8'h78, 8'h00, 0};
    for (int j = 0; j < 4; j++)
      bus(1, j, 8'h00);
  endtask
  task automatic scramble();
    repeat (8)
    begin
      i = $urandom_range(3, 1);
      d = 8'($urandom);
      m[i] = (i == 1) ? d | 8'h78 : (i == 3) ? 0 : d;
      bus(0, i, d);
      bus(1, i, 8'h00);
    end
    repeat (2) @(posedge clk_in);
    #1;
    check({clk_out_oe_out, halt_serial1_out, halt_serial0_out, halt_timer16_out, halt_timer8_ch01_out,
           halt_timer8_ch23_out, halt_adc_out}, {!m[1][7], m[1][1:0], m[2][4:2], m[2][0]});
  endtask
  task automatic halt();
    @(posedge clk_in);
    halt_exec_in <= 1'b1;
    @(posedge clk_in);
    halt_exec_in <= 1'b0;
  endtask
  task automatic wait_mode(input logic [2:0] md);
    n = 0;
    while (mode_out !== md && n < 9000)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (mode_out !== md)
    begin
      err_count++;
      complete_run();
    end
  endtask
  initial
  begin
    {rst_in, reset_pin_n_in, hw_standby_n_in} = 3'b111;
    {write_in, read_in, halt_exec_in} = 3'b000;
    addr_in = 24'h00_0000;
    wdata_in = 8'h00;
    kind = 2'h0;
    lag = 8'hC8;
    ra = '{`PDMH_SYSCTL_ADDR, `PDMH_HALT_HI_ADDR, `PDMH_HALT_LO_ADDR, 20'hE_E01E};
    void'($urandom(44937));
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    reset_regs();
    scramble();
    kind <= 2'h1;
    halt();
    wait_mode(3'h1);
    check({cpu_stop_out, clock_stop_out, io_hold_out, clk_out_level_out, periph_reset_out}, 5'h14);
    // halt bits stay writable while the processor sleeps
    scramble();
    wait_mode(3'h0);
    for (k = 2; k < 4; k++)
    begin
      @(posedge clk_in);
      kind <= 2'h1;
      lag <= 8'($urandom_range(20, 1));
      // short wait code first, then the default code for the unshifted 8192 length
      m[0] = (k == 2) ? 8'hE9 : 8'h89;
      bus(0, 0, m[0][7:0]);
      halt();
      wait_mode(3'h2);
      check({cpu_stop_out, clock_stop_out, periph_reset_out, clk_out_level_out, io_hold_out}, 5'h1F);
      repeat (30) @(posedge clk_in);
      kind <= k[1:0];
      #1;
      check(mode_out, 3'h2);
      wait_mode(3'h3);
      check({cpu_stop_out, clock_stop_out, periph_reset_out, clk_out_level_out, io_hold_out}, 5'h1A);
      wait_mode(3'h0);
      check(20'(n), (k == 2) ? 20'h0_0400 : 20'h0_2000);
      bus(1, 0, 8'h00);
    end
    @(posedge clk_in);
    kind <= 2'h0;
    hw_standby_n_in <= 1'b0;
    wait_mode(3'h4);
    check({io_oe_out, clk_out_oe_out, cpu_regs_lost_out, periph_reset_out}, 4'h3);
    @(posedge clk_in);
    hw_standby_n_in <= 1'b1;
    wait_mode(3'h0);
    reset_regs();
    // dirty the halt registers so the reset pin has something to reload
    scramble();
    halt();
    wait_mode(3'h1);
    @(posedge clk_in);
    reset_pin_n_in <= 1'b0;
    wait_mode(3'h0);
    @(posedge clk_in);
    reset_pin_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    reset_regs();
    bus(0, 2, 8'h1D);
    repeat (2) @(posedge clk_in);
    #1;
    check({halt_timer16_out, halt_timer8_ch01_out, halt_timer8_ch23_out, halt_adc_out}, 4'hF);
    bus(0, 2, 8'h00);
    repeat (2) @(posedge clk_in);
    #1;
    check({halt_timer16_out, halt_timer8_ch01_out, halt_timer8_ch23_out, halt_adc_out}, 4'h0);
    complete_run();
  end
endmodule
